// ==== hdl/fbod_host.sv ====
// Host controller that runs read, write, protect and reset cycles on the flash pins
module fbod_host (
    // Clock, reset, enable
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_clk_en,
    // User request
    input wire logic i_req,
    input wire fbod_pkg::fbod_op_t i_req_op,
    input wire logic [fbod_pkg::ADDR_W-1:0] i_req_addr,
    input wire logic [fbod_pkg::DATA_W-1:0] i_req_data,
    input wire logic i_byte_mode,
    // User answer
    output logic o_req_ready,
    output logic o_done,
    output logic [fbod_pkg::DATA_W-1:0] o_rdata,
    // Flash control pins
    output logic o_chip_sel_n,
    output logic o_out_en_n,
    output logic o_wr_en_n,
    output logic o_reset_n,
    output logic o_high_voltage_level,
    output logic o_width_word,
    output logic [fbod_pkg::PIN_ADDR_W-1:0] o_addr,
    // Flash data pins
    input wire logic [fbod_pkg::DATA_W-1:0] i_data_pins,
    output logic [fbod_pkg::DATA_W-1:0] o_data_pins,
    output logic [fbod_pkg::DATA_W-1:0] o_data_pins_oe,
    // Ready/busy from flash
    input wire logic i_ready_busy_n
);
    import fbod_pkg::*;

    fbod_state_t state;
    fbod_state_t next_state;
    fbod_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic byte_mode;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;

    function automatic logic [CNT_W-1:0] cyc(input int n);
        return CNT_W'(n - 1);
    endfunction

    function automatic logic [CNT_W-1:0] dec(input logic [CNT_W-1:0] c);
        return c - 1'b1;
    endfunction

    // States in which the flash is selected
    function automatic logic is_cycle(input fbod_state_t s);
        return (s == FBOD_ST_SETUP) || (s == FBOD_ST_READ) || (s == FBOD_ST_STROBE) || (s == FBOD_ST_HOLD);
    endfunction

    // Protect address: A6 picks protect or unprotect, A1 high, A0 low.
    // In byte mode the pins sit one bit up, above the lane-select bit
    function automatic logic [ADDR_W-1:0] prot_addr(input logic [ADDR_W-1:0] a, input logic unprot,
                                                    input logic bytes);
        logic [ADDR_W-1:0] r;
        int sh;
        r = a;
        sh = int'(bytes);
        r[BIT_A6 + sh] = unprot; // RQ18 RQ19
        r[BIT_A1 + sh] = 1'b1; // RQ18
        r[BIT_A0 + sh] = 1'b0; // RQ18
        return r;
    endfunction

    wire is_hv = (op == FBOD_OP_PROTECT) || (op == FBOD_OP_UNPROTECT);
    wire is_rd = (op == FBOD_OP_READ);
    wire cnt_zero = (cnt == '0);
    wire take = i_clk_en && o_req_ready && i_req;
    wire hv_take = (i_req_op == FBOD_OP_PROTECT) || (i_req_op == FBOD_OP_UNPROTECT);
    // Protect bits set before latching, so the pins need no later patching
    wire [ADDR_W-1:0] take_addr = hv_take ?
                                  prot_addr(i_req_addr, i_req_op == FBOD_OP_UNPROTECT, i_byte_mode) : i_req_addr;
    wire in_cycle = is_cycle(state);
    // Word address from upper bits in byte mode; lowest bit rides on pin 15
    wire [PIN_ADDR_W-1:0] pin_addr = byte_mode ? addr[ADDR_W-1:1] : addr[PIN_ADDR_W-1:0]; // RQ6
    wire drive_data = in_cycle && !is_rd;
    wire [DATA_W-1:0] wr_oe = byte_mode ? OE_BYTE : OE_WORD; // RQ3 RQ4 RQ13
    wire [DATA_W-1:0] rd_oe = byte_mode ? OE_BYTE_RD : '0; // RQ5
    wire [DATA_W-1:0] wr_pins = byte_mode ? {addr[0], 7'h00, wdata[7:0]} : wdata; // RQ5
    wire [DATA_W-1:0] rd_pins = byte_mode ? {addr[0], 15'h0000} : '0;
    // Identification codes and byte reads only use the low lane
    wire [DATA_W-1:0] rd_capt = byte_mode ? {8'h00, i_data_pins[7:0]} : i_data_pins; // RQ17

    // Every phase counts enabled cycles only, so a low enable stretches it
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        unique case (state)
            FBOD_ST_IDLE: begin
                if (take) begin
                    if (i_req_op == FBOD_OP_RESET) begin
                        next_state = FBOD_ST_RST_LOW;
                        next_cnt = cyc(RP_CYC);
                    end else begin
                        next_state = FBOD_ST_SETUP;
                        next_cnt = hv_take ? cyc(HV_CYC) : cyc(SETUP_CYC);
                    end
                end
            end
            FBOD_ST_SETUP: begin
                if (cnt_zero) begin
                    next_state = is_rd ? FBOD_ST_READ : FBOD_ST_STROBE;
                    next_cnt = is_rd ? cyc(ACC_CYC) : cyc(WP_CYC);
                end else begin
                    next_cnt = dec(cnt);
                end
            end
            FBOD_ST_READ, FBOD_ST_STROBE: begin
                if (cnt_zero) begin
                    next_state = FBOD_ST_HOLD;
                end else begin
                    next_cnt = dec(cnt);
                end
            end
            FBOD_ST_HOLD: begin
                next_state = FBOD_ST_IDLE;
            end
            FBOD_ST_RST_LOW: begin
                if (cnt_zero) begin
                    next_state = FBOD_ST_RST_REC;
                    next_cnt = cyc(RH_CYC);
                end else begin
                    next_cnt = dec(cnt);
                end
            end
            FBOD_ST_RST_REC: begin
                if (cnt_zero) begin
                    next_state = FBOD_ST_IDLE;
                end else begin
                    next_cnt = dec(cnt);
                end
            end
            default: begin
                next_state = FBOD_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state <= FBOD_ST_IDLE;
            cnt <= '0;
        end else if (i_clk_en) begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    // Request latched once so pins stay stable for the whole cycle
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            op <= FBOD_OP_READ;
            addr <= '0;
            wdata <= '0;
            byte_mode <= 1'b0;
        end else if (take) begin
            op <= i_req_op;
            addr <= take_addr;
            wdata <= i_req_data;
            byte_mode <= i_byte_mode;
        end
    end

    // Pin levels for the coming cycle, registered so the flash sees clean edges
    wire next_done = (state == FBOD_ST_HOLD) || (state == FBOD_ST_RST_REC && cnt_zero);
    // Last access cycle: output enable is still low at this edge
    wire capt_rd = (state == FBOD_ST_READ) && cnt_zero;
    wire next_chip_sel_n = !is_cycle(next_state); // RQ8 RQ23
    wire next_out_en_n = !(next_state == FBOD_ST_READ && is_rd); // RQ7 RQ21
    // Write enable only while output enable is high
    wire next_wr_en_n = !(next_state == FBOD_ST_STROBE); // RQ12 RQ24 RQ14
    wire next_reset_n = !(next_state == FBOD_ST_RST_LOW); // RQ20 RQ22 RQ9
    // High voltage rises with select, so it is settled before the write strobe
    wire next_hv = in_cycle ? is_hv : (take && hv_take); // RQ18 RQ25
    wire next_width_word = take ? !i_byte_mode : !byte_mode; // RQ3 RQ4
    wire [DATA_W-1:0] next_pins = drive_data ? wr_pins : rd_pins;
    // Host lanes released the cycle after select rises, while the flash floats in standby, so they never fight it
    wire [DATA_W-1:0] next_pins_oe = in_cycle ? (drive_data ? wr_oe : rd_oe) : '0;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_rdata <= '0;
            o_done <= 1'b0;
        end else if (i_clk_en) begin
            o_done <= next_done;
            if (capt_rd) begin
                o_rdata <= rd_capt; // RQ10
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_chip_sel_n <= 1'b1;
            o_out_en_n <= 1'b1;
            o_wr_en_n <= 1'b1;
            o_reset_n <= 1'b1;
            o_high_voltage_level <= 1'b0;
            o_width_word <= 1'b1;
            o_addr <= '0;
            o_data_pins <= '0;
            o_data_pins_oe <= '0;
        end else if (i_clk_en) begin
            o_chip_sel_n <= next_chip_sel_n;
            o_out_en_n <= next_out_en_n;
            o_wr_en_n <= next_wr_en_n;
            o_reset_n <= next_reset_n;
            o_high_voltage_level <= next_hv;
            o_width_word <= next_width_word;
            o_addr <= pin_addr; // RQ16
            o_data_pins <= next_pins;
            o_data_pins_oe <= next_pins_oe;
        end
    end

    // New requests wait for idle; busy flash is polled by the user
    assign o_req_ready = (state == FBOD_ST_IDLE) && !i_rst;

    // Busy pin not watched: completion is polled by the user through status reads
    wire unused_rb = i_ready_busy_n;
endmodule

// ==== hdl/fbod_pkg.sv ====
// Constants, operation codes and pin timing for the flash bus host controller
// Operation
// RQ1: Command register is internal, not addressable
// RQ2: Written command latches address and data
// RQ3: Width select high gives sixteen data pins
// RQ4: Width select low gives eight data pins
// RQ5: Byte mode floats 8-14, pin 15 addresses
// RQ6: Word uses 17 address bits, byte 18
// RQ7: Read: select and output enable low
// RQ8: Select powers device, output enable gates data
// RQ9: Reset returns device to array read
// RQ10: Array read needs no prior command
// RQ11: Array read holds until a command write
// RQ12: Write: write enable, select low, OE high
// RQ13: Program data width follows width select
// RQ14: Fast program needs two writes, not four
// RQ15: Erase one sector, several, or all
// RQ16: Sector named by its upper address bits
// RQ17: Identification codes come on low byte
// RQ18: Protect: high voltage reset, A6 low write
// RQ19: Unprotect: same cycle with A6 high
// RQ20: Hardware reset pin is active low
// RQ21: Output enable high floats data outputs
// RQ22: Reset low aborts, floats, ignores cycles
// RQ23: Select high means standby, outputs float
// RQ24: Never output and write enable together
// RQ25: High voltage reset unlocks protected sectors
package fbod_pkg;
    localparam int CLK_NS = 10;
    localparam int T_ACC_NS = 120;
    localparam int T_WP_NS = 50;
    localparam int T_SETUP_NS = 10;
    localparam int T_RP_NS = 500;
    localparam int T_RH_NS = 50;
    localparam int T_HV_NS = 100;
    localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETUP_CYC = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int RP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS;
    localparam int RH_CYC = (T_RH_NS + CLK_NS - 1) / CLK_NS;
    localparam int HV_CYC = (T_HV_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 8;
    localparam int ADDR_W = 18;
    localparam int PIN_ADDR_W = 17;
    localparam int DATA_W = 16;
    localparam int BIT_A6 = 6;
    localparam int BIT_A1 = 1;
    localparam int BIT_A0 = 0;
    localparam logic [DATA_W-1:0] OE_WORD = 16'hFFFF;
    localparam logic [DATA_W-1:0] OE_BYTE = 16'h80FF;
    localparam logic [DATA_W-1:0] OE_BYTE_RD = 16'h8000;

    typedef enum logic [2:0] {
        FBOD_OP_READ = 3'h0,
        FBOD_OP_WRITE = 3'h1,
        FBOD_OP_PROTECT = 3'h2,
        FBOD_OP_UNPROTECT = 3'h3,
        FBOD_OP_RESET = 3'h4
    } fbod_op_t;

    typedef enum logic [2:0] {
        FBOD_ST_IDLE = 3'h0,
        FBOD_ST_SETUP = 3'h1,
        FBOD_ST_READ = 3'h2,
        FBOD_ST_STROBE = 3'h3,
        FBOD_ST_HOLD = 3'h4,
        FBOD_ST_RST_LOW = 3'h5,
        FBOD_ST_RST_REC = 3'h6
    } fbod_state_t;
endpackage

// ==== tb/fbod_flash_model.sv ====
// Behavioural flash device seen across the host pins
module fbod_flash_model (
    // Control pins
    input wire logic i_chip_sel_n,
    input wire logic i_out_en_n,
    input wire logic i_wr_en_n,
    input wire logic i_reset_n,
    input wire logic i_width_word,
    // Address and data
    input wire logic [16:0] i_addr,
    input wire logic [15:0] i_bus,
    output logic [15:0] o_q
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [0:255];
    logic [15:0] last = 16'h0000;
    logic [16:0] cmd_addr;
    logic [15:0] cmd_data;
    wire [7:0] idx = i_addr[7:0];
    wire hi = !i_width_word && i_bus[15];
    wire [15:0] wq = mem[idx];
    wire [15:0] val = i_width_word ? wq : {8'h00, hi ? wq[15:8] : wq[7:0]};
    wire rd = !i_chip_sel_n && !i_out_en_n && i_reset_n;
    // No pull on this bus: released lines show the inverse
    assign o_q = {rd && i_width_word ? val[15:8] : ~last[15:8], rd ? val[7:0] : ~last[7:0]};
    initial for (int i = 0; i < 256; i++) mem[i] = 16'hFFFF;
    always @(negedge rd) last <= val;
    always @(posedge i_wr_en_n) begin
        if (!i_chip_sel_n && i_out_en_n && i_reset_n) begin
            cmd_addr <= i_addr;
            cmd_data <= i_bus;
            if (i_width_word) mem[idx] <= i_bus;
            else if (hi) mem[idx][15:8] <= i_bus[7:0];
            else mem[idx][7:0] <= i_bus[7:0];
        end
    end
endmodule

// ==== tb/fbod_host_sva.sv ====
// Pin-level checker for the flash bus host controller
module fbod_host_sva (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_clk_en,
    input wire logic i_req,
    input wire fbod_pkg::fbod_op_t i_req_op,
    input wire logic o_req_ready,
    input wire logic o_done,
    input wire logic o_chip_sel_n,
    input wire logic o_out_en_n,
    input wire logic o_wr_en_n,
    input wire logic o_reset_n,
    input wire logic o_high_voltage_level,
    input wire logic o_width_word,
    input wire logic [fbod_pkg::PIN_ADDR_W-1:0] o_addr,
    input wire logic [fbod_pkg::DATA_W-1:0] o_data_pins_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    import fbod_pkg::*;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    sequence s_take(fbod_op_t op); i_clk_en && i_req && o_req_ready && i_req_op == op; endsequence
    property p_excl; !(!o_out_en_n && !o_wr_en_n); endproperty
    a_excl: assert property (p_excl) else $error("strobes overlap");
    property p_read; !o_out_en_n |-> !o_chip_sel_n && o_wr_en_n && o_reset_n; endproperty
    a_read: assert property (p_read) else $error("bad read levels");
    property p_write; !o_wr_en_n |-> !o_chip_sel_n && o_out_en_n; endproperty
    a_write: assert property (p_write) else $error("bad write levels");
    property p_float; !o_width_word && !o_chip_sel_n |-> o_data_pins_oe[14:8] == 7'h00; endproperty
    a_float: assert property (p_float) else $error("upper lane driven");
    property p_wdata; !o_wr_en_n |-> o_data_pins_oe[7:0] == 8'hFF; endproperty
    a_wdata: assert property (p_wdata) else $error("write data not driven");
    property p_prot; o_high_voltage_level && !o_wr_en_n |-> o_addr[BIT_A1] && !o_addr[BIT_A0]; endproperty
    a_prot: assert property (p_prot) else $error("bad protect address");
    property p_hv; s_take(FBOD_OP_PROTECT) |-> ##1 o_high_voltage_level; endproperty
    a_hv: assert property (p_hv) else $error("no high voltage");
    sequence s_pin_addr(logic a6); o_addr[BIT_A6] == a6 && o_addr[BIT_A1] && !o_addr[BIT_A0]; endsequence
    property p_pset; s_take(FBOD_OP_PROTECT) |-> ##2 s_pin_addr(1'b0); endproperty
    a_pset: assert property (p_pset) else $error("bad protect pins");
    property p_punset; s_take(FBOD_OP_UNPROTECT) |-> ##1 o_high_voltage_level ##1 s_pin_addr(1'b1); endproperty
    a_punset: assert property (p_punset) else $error("bad unprotect pins");
    property p_wdone; s_take(FBOD_OP_WRITE) |-> ##8 o_done; endproperty
    a_wdone: assert property (p_wdone) else $error("write done late");
    property p_rst; s_take(FBOD_OP_RESET) |-> ##1 !o_reset_n [*8] ##42 !o_reset_n ##1 o_reset_n; endproperty
    a_rst: assert property (p_rst) else $error("bad reset pulse");
endmodule
bind fbod_host fbod_host_sva u_sva (.i_ref_clk, .i_rst, .i_clk_en, .i_req, .i_req_op, .o_req_ready, .o_done,
    .o_chip_sel_n, .o_out_en_n, .o_wr_en_n, .o_reset_n, .o_high_voltage_level, .o_width_word, .o_addr,
    .o_data_pins_oe);

// ==== tb/tb.sv ====
// Self-checking bench for the flash bus host controller
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value at %0t: %h %h", $time, g, e); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fbod_pkg::*;
    logic clk = 0, rst = 1, req = 0, bm = 0, en = 1;
    fbod_op_t op = FBOD_OP_READ;
    logic [17:0] addr = 18'h00000;
    logic [15:0] wd = 16'h0000;
    logic ready, done, ce_n, oe_n, we_n, rst_n, hv, word;
    logic [15:0] rdata, pout, poe, dq, bus;
    logic [16:0] pa;
    int miscompares = 0, n_checks = 0;
    // Host lanes win where enabled, the device fills the rest
    assign bus = (poe & pout) | (~poe & dq);
    initial forever #5 clk = ~clk;
    fbod_host u_dut (.i_ref_clk(clk), .i_rst(rst), .i_clk_en(en), .i_req(req), .i_req_op(op), .i_req_addr(addr),
        .i_req_data(wd), .i_byte_mode(bm), .o_req_ready(ready), .o_done(done), .o_rdata(rdata),
        .o_chip_sel_n(ce_n), .o_out_en_n(oe_n), .o_wr_en_n(we_n), .o_reset_n(rst_n), .o_high_voltage_level(hv),
        .o_width_word(word), .o_addr(pa), .i_data_pins(bus), .o_data_pins(pout), .o_data_pins_oe(poe),
        .i_ready_busy_n(1'b1));
    fbod_flash_model u_flash (.i_chip_sel_n(ce_n), .i_out_en_n(oe_n), .i_wr_en_n(we_n), .i_reset_n(rst_n),
        .i_width_word(word), .i_addr(pa), .i_bus(bus), .o_q(dq));
    task automatic wait_done;
        for (int n = 0; n < 80 && done !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
    endtask
    task automatic run(input fbod_op_t o, input logic [17:0] a, input logic [15:0] d, input logic b);
        @(posedge clk);
        op <= o;
        addr <= a;
        wd <= d;
        bm <= b;
        req <= 1'b1;
        @(posedge clk);
        req <= 1'b0;
        wait_done();
        `CHK(done, 1'b1)
    endtask
    task automatic t_power_up;
        `CHK(ready, 1'b1)
        `CHK(rst_n, 1'b1)
        `CHK(poe, 16'h0000)
        run(FBOD_OP_READ, 18'h00005, 16'h0000, 1'b0);
        `CHK(rdata, 16'hFFFF)
    endtask
    task automatic t_word;
        run(FBOD_OP_WRITE, 18'h00012, 16'hA5C3, 1'b0);
        run(FBOD_OP_READ, 18'h00012, 16'h0000, 1'b0);
        `CHK(rdata, 16'hA5C3)
    endtask
    task automatic t_byte;
        run(FBOD_OP_WRITE, 18'h00025, 16'h005A, 1'b1);
        run(FBOD_OP_READ, 18'h00025, 16'h0000, 1'b1);
        `CHK(rdata, 16'h005A)
        run(FBOD_OP_READ, 18'h00024, 16'h0000, 1'b1);
        `CHK(rdata, 16'h00C3)
        run(FBOD_OP_READ, 18'h00012, 16'h0000, 1'b0);
        `CHK(rdata, 16'h5AC3)
    endtask
    task automatic t_protect;
        run(FBOD_OP_PROTECT, 18'h1C002, 16'h0000, 1'b0);
        `CHK(u_flash.cmd_addr, 17'h1C002)
        run(FBOD_OP_UNPROTECT, 18'h1C002, 16'h0000, 1'b0);
        `CHK(u_flash.cmd_addr, 17'h1C042)
        run(FBOD_OP_PROTECT, 18'h380C6, 16'h0000, 1'b1);
        `CHK(u_flash.cmd_addr, 17'h1C022)
        run(FBOD_OP_READ, 18'h00012, 16'h0000, 1'b0);
        `CHK(rdata, 16'h5AC3)
    endtask
    task automatic t_freeze;
        @(posedge clk);
        op <= FBOD_OP_READ;
        addr <= 18'h00012;
        bm <= 1'b0;
        req <= 1'b1;
        @(posedge clk);
        req <= 1'b0;
        repeat (3) @(posedge clk);
        en <= 1'b0;
        repeat (20) @(posedge clk);
        #1;
        `CHK(ce_n, 1'b0)
        `CHK(oe_n, 1'b0)
        `CHK(ready, 1'b0)
        `CHK(done, 1'b0)
        @(posedge clk);
        en <= 1'b1;
        wait_done();
        `CHK(done, 1'b1)
        `CHK(rdata, 16'h5AC3)
    endtask
    task automatic t_abort;
        @(posedge clk);
        op <= FBOD_OP_WRITE;
        addr <= 18'h00030;
        wd <= 16'h1234;
        bm <= 1'b0;
        req <= 1'b1;
        @(posedge clk);
        req <= 1'b0;
        repeat (3) @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        #1;
        `CHK(ce_n, 1'b1)
        `CHK(we_n, 1'b1)
        `CHK(poe, 16'h0000)
        `CHK(ready, 1'b0)
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        `CHK(ready, 1'b1)
        run(FBOD_OP_READ, 18'h00030, 16'h0000, 1'b0);
        `CHK(rdata, 16'hFFFF)
    endtask
    task automatic t_reset;
        run(FBOD_OP_RESET, 18'h00000, 16'h0000, 1'b0);
        run(FBOD_OP_READ, 18'h00012, 16'h0000, 1'b0);
        `CHK(rdata, 16'h5AC3)
    endtask
    task automatic results;
        if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #40000;
        miscompares++;
        results();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        t_power_up();
        t_word();
        t_byte();
        t_protect();
        t_freeze();
        t_abort();
        t_reset();
        results();
    end
endmodule
